// [verilog/mii_rx_sta.sv]
`timescale 1ns/100ps
// Behaviour
// - management clock output runs at 1.5 MHz while a frame is in flight, is parked low when idle, and times the data line.
// - management data bits launched at management clock falling edge and sampled at its rising edge.
// - frames follow standard MII management format; data line pulled up.
// - management interrupt input accepted; idles high through pull-up.
module mii_rx_sta #(
  parameter int unsigned DEPTH = mii_rx_sta_pkg::FIFO_DEPTH
) (
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RST_IN,
  // receive side of the link, on the PHY clock
  input  wire logic        RX_CLK_IN,
  input  wire logic [3:0]  RX_NIBBLE_IN,
  input  wire logic        RX_VALID_IN,
  input  wire logic        RX_ERROR_IN,
  input  wire logic        COLLISION_IN,
  input  wire logic        CARRIER_IN,
  // receive stream out, core clock
  output logic      [3:0]  RX_DATA_OUT,
  output logic             RX_LAST_OUT,
  output logic             RX_BAD_OUT,
  output logic             RX_COL_OUT,
  output logic             RX_STREAM_VALID_OUT,
  input  wire logic        RX_STREAM_READY_IN,
  output logic             RX_OVERFLOW_OUT,
  output logic             COLLISION_OUT,
  output logic             CARRIER_OUT,
  // management port pins
  output logic             MGMT_CLK_OUT,
  input  wire logic        MGMT_DATA_IN,
  output logic             MGMT_DATA_OUT,
  output logic             MGMT_DATA_OE_OUT,
  input  wire logic        MGMT_INT_N_IN,
  output logic             MGMT_INT_OUT,
  // management command port
  input  wire logic        MGMT_START_IN,
  input  wire logic        MGMT_WRITE_IN,
  input  wire logic [4:0]  MGMT_PHY_ADDR_IN,
  input  wire logic [4:0]  MGMT_REG_ADDR_IN,
  input  wire logic [15:0] MGMT_WDATA_IN,
  output logic             MGMT_BUSY_OUT,
  output logic             MGMT_DONE_OUT,
  output logic      [15:0] MGMT_RDATA_OUT
);
  localparam int unsigned WW = mii_rx_sta_pkg::WORD_W;

  // =====================================================================
  // receive clock domain: capture and frame tagging
  // =====================================================================
  logic [3:0]  rxn_q, rxn_d;
  logic        rxv_q, rxv_d, rxe_q, rxe_d, bad_q, bad_d;
  logic        pend_q, pend_d;
  logic [3:0]  pnib_q, pnib_d;
  logic        pbad_q, pbad_d, pcol_q, pcol_d;
  logic        col_l1_q, col_l2_q;
  logic        tog_q, tog_d;
  logic [WW-1:0] xw_q, xw_d;

  // register pins first, then hold one nibble back so the last can be marked
  always_comb begin
    rxn_d  = RX_NIBBLE_IN;
    rxv_d  = RX_VALID_IN;
    rxe_d  = RX_ERROR_IN;
    bad_d  = rxv_q ? (bad_q | rxe_q) : 1'b0;
    pend_d = pend_q;
    pnib_d = pnib_q;
    pbad_d = pbad_q;
    pcol_d = pcol_q;
    tog_d  = tog_q;
    xw_d   = xw_q;
    if (pend_q) begin
      // flush held nibble; it is last when valid has dropped
      tog_d  = ~tog_q;
      xw_d   = {!rxv_q, pbad_q | (!rxv_q & rxe_q), pcol_q, pnib_q};
      pend_d = 1'b0;
    end
    if (rxv_q) begin
      pend_d = 1'b1;
      pnib_d = rxn_q;
      pbad_d = bad_q | rxe_q;
      pcol_d = col_l2_q;
    end
  end

  always_ff @(posedge RX_CLK_IN) begin
    if (RST_IN) begin
      rxn_q  <= '0;
      rxv_q  <= 1'b0;
      rxe_q  <= 1'b0;
      bad_q  <= 1'b0;
      pend_q <= 1'b0;
      pnib_q <= '0;
      pbad_q <= 1'b0;
      pcol_q <= 1'b0;
      tog_q  <= 1'b0;
      xw_q   <= '0;
    end else begin
      rxn_q  <= rxn_d;
      rxv_q  <= rxv_d;
      rxe_q  <= rxe_d;
      bad_q  <= bad_d;
      pend_q <= pend_d;
      pnib_q <= pnib_d;
      pbad_q <= pbad_d;
      pcol_q <= pcol_d;
      tog_q  <= tog_d;
      xw_q   <= xw_d;
    end
  end

  // collision seen on the link side too, for tagging nibbles
  always_ff @(posedge RX_CLK_IN) begin
    if (RST_IN) begin
      col_l1_q <= 1'b0;
      col_l2_q <= 1'b0;
    end else begin
      col_l1_q <= COLLISION_IN;
      col_l2_q <= col_l1_q;
    end
  end

  // =====================================================================
  // core domain: word crossing by toggle, status synchronisers
  // =====================================================================
  // one word per receive clock (>=160 ns) against 10 ns core clock, so the
  // held word is stable long before the toggle edge reaches the core side
  logic [2:0]    tg_q, tg_d;
  logic [WW-1:0] cw_q, cw_d;
  logic          cv_q, cv_d;
  logic [1:0]    col_s_q, col_s_d, crs_s_q, crs_s_d, int_s_q, int_s_d;
  logic          ovf_q, ovf_d;
  logic          f_ready, f_valid;
  logic [WW-1:0] f_data;

  always_comb begin
    tg_d    = {tg_q[1:0], tog_q};
    col_s_d = {col_s_q[0], COLLISION_IN};
    crs_s_d = {crs_s_q[0], CARRIER_IN};
    // pin goes raw into the first flop; inversion waits for the output stage
    int_s_d = {int_s_q[0], MGMT_INT_N_IN};
    cw_d    = cw_q;
    cv_d    = cv_q && !f_ready;
    ovf_d   = ovf_q;
    if (tg_q[2] != tg_q[1]) begin
      cw_d = xw_q;
      cv_d = 1'b1;
      ovf_d = ovf_q | (cv_q && !f_ready); // a stalled reader loses a word
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      tg_q    <= '0;
      cw_q    <= '0;
      cv_q    <= 1'b0;
      col_s_q <= '0;
      crs_s_q <= '0;
      int_s_q <= 2'h3;
      ovf_q   <= 1'b0;
    end else begin
      tg_q    <= tg_d;
      cw_q    <= cw_d;
      cv_q    <= cv_d;
      col_s_q <= col_s_d;
      crs_s_q <= crs_s_d;
      int_s_q <= int_s_d;
      ovf_q   <= ovf_d;
    end
  end

  // =====================================================================
  // receive fifo and registered stream outputs
  // =====================================================================
  rx_word_fifo #(
    .WIDTH (WW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_in       (CORE_CLK_IN),
    .rst_in       (RST_IN),
    .wr_data_in   (cw_q),
    .wr_valid_in  (cv_q),
    .wr_ready_out (f_ready),
    .rd_data_out  (f_data),
    .rd_valid_out (f_valid),
    .rd_ready_in  (!RX_STREAM_VALID_OUT || RX_STREAM_READY_IN)
  );

  // output stage registered so every port comes from a flip-flop
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      RX_STREAM_VALID_OUT <= 1'b0;
      RX_DATA_OUT         <= '0;
      RX_LAST_OUT         <= 1'b0;
      RX_BAD_OUT          <= 1'b0;
      RX_COL_OUT          <= 1'b0;
    end else if (!RX_STREAM_VALID_OUT || RX_STREAM_READY_IN) begin
      RX_STREAM_VALID_OUT <= f_valid;
      RX_DATA_OUT         <= f_data[mii_rx_sta_pkg::NIBBLE_W-1:0];
      RX_LAST_OUT         <= f_data[mii_rx_sta_pkg::WORD_LAST_BIT];
      RX_BAD_OUT          <= f_data[mii_rx_sta_pkg::WORD_ERR_BIT];
      RX_COL_OUT          <= f_data[mii_rx_sta_pkg::WORD_COL_BIT];
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      COLLISION_OUT   <= 1'b0;
      CARRIER_OUT     <= 1'b0;
      MGMT_INT_OUT    <= 1'b0;
      RX_OVERFLOW_OUT <= 1'b0;
    end else begin
      COLLISION_OUT   <= col_s_q[1];
      CARRIER_OUT     <= crs_s_q[1];
      MGMT_INT_OUT    <= ~int_s_q[1];
      RX_OVERFLOW_OUT <= ovf_q;
    end
  end

  // =====================================================================
  // station management: clock divider and frame sequencer
  // =====================================================================
  mii_rx_sta_pkg::mgmt_state_e st_q, st_d;
  logic [mii_rx_sta_pkg::MGMT_DIV_W-1:0] div_q, div_d;
  logic        mdc_q, mdc_d, rise, fall;
  logic [mii_rx_sta_pkg::BIT_CNT_W-1:0] bit_q, bit_d;
  logic [63:0] sh_q, sh_d;
  logic        wr_q, wr_d, oe_q, oe_d, do_q, do_d, done_q, done_d;
  logic        busy_q, busy_d;
  logic [15:0] rd_q, rd_d;
  logic [1:0]  mdi_s_q;

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      mdi_s_q <= 2'b11;
    end else begin
      mdi_s_q <= {mdi_s_q[0], MGMT_DATA_IN};
    end
  end

  always_comb begin
    div_d = (div_q == mii_rx_sta_pkg::MGMT_DIV_W'(mii_rx_sta_pkg::MGMT_HALF_CYC - 1))
            ? '0 : div_q + 1'b1;
    rise  = (div_q == '0) && (mdc_q == 1'b0) && (st_q != mii_rx_sta_pkg::MG_IDLE);
    fall  = (div_q == '0) && mdc_q;
    // free-running 1.5 MHz while a frame is in flight, parked low when idle
    mdc_d = (div_q == '0) ? (rise ? 1'b1 : 1'b0) : mdc_q;
    st_d  = st_q;
    bit_d = bit_q;
    sh_d  = sh_q;
    wr_d  = wr_q;
    oe_d  = oe_q;
    do_d  = do_q;
    rd_d  = rd_q;
    done_d = 1'b0;
    case (st_q)
      mii_rx_sta_pkg::MG_IDLE: begin
        oe_d = 1'b0;
        if (MGMT_START_IN) begin
          // first preamble bit leaves now, so the first rise already carries bit 0
          sh_d = {{(mii_rx_sta_pkg::PREAMBLE_BITS-1){1'b1}}, mii_rx_sta_pkg::START_CODE,
                  MGMT_WRITE_IN ? mii_rx_sta_pkg::OP_WRITE : mii_rx_sta_pkg::OP_READ,
                  MGMT_PHY_ADDR_IN, MGMT_REG_ADDR_IN, mii_rx_sta_pkg::TA_WRITE,
                  MGMT_WRITE_IN ? MGMT_WDATA_IN : 16'h0000, 1'b0};
          do_d  = 1'b1;
          oe_d  = 1'b1;
          // restart the divider so bit 0 gets a full half period of set-up
          div_d = mii_rx_sta_pkg::MGMT_DIV_W'(1);
          wr_d  = MGMT_WRITE_IN;
          bit_d = '0;
          st_d  = mii_rx_sta_pkg::MG_SHIFT;
        end
      end
      mii_rx_sta_pkg::MG_SHIFT: begin
        // launch on the falling edge so the PHY sees it stable at the rise
        if (fall) begin
          do_d = sh_q[63];
          sh_d = {sh_q[62:0], 1'b0};
          oe_d = wr_q || (bit_q < mii_rx_sta_pkg::BIT_CNT_W'(mii_rx_sta_pkg::TA_BIT_POS));
        end
        if (rise) begin
          if (!wr_q && bit_q >= mii_rx_sta_pkg::BIT_CNT_W'(mii_rx_sta_pkg::DATA_BIT_POS)) begin
            rd_d = {rd_q[14:0], mdi_s_q[1]};
          end
          bit_d = bit_q + 1'b1;
          if (bit_q == mii_rx_sta_pkg::BIT_CNT_W'(mii_rx_sta_pkg::FRAME_BITS - 1)) begin
            st_d = mii_rx_sta_pkg::MG_DONE;
          end
        end
      end
      mii_rx_sta_pkg::MG_DONE: begin
        if (fall) begin
          oe_d   = 1'b0;
          done_d = 1'b1;
          st_d   = mii_rx_sta_pkg::MG_IDLE;
        end
      end
      default: st_d = mii_rx_sta_pkg::MG_IDLE;
    endcase
    // busy registered so the port comes straight from a flop
    busy_d = (st_d != mii_rx_sta_pkg::MG_IDLE);
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      st_q   <= mii_rx_sta_pkg::MG_IDLE;
      div_q  <= '0;
      mdc_q  <= 1'b0;
      bit_q  <= '0;
      sh_q   <= '0;
      wr_q   <= 1'b0;
      oe_q   <= 1'b0;
      do_q   <= 1'b1;
      rd_q   <= '0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      div_q  <= div_d;
      mdc_q  <= mdc_d;
      bit_q  <= bit_d;
      sh_q   <= sh_d;
      wr_q   <= wr_d;
      oe_q   <= oe_d;
      do_q   <= do_d;
      rd_q   <= rd_d;
      done_q <= done_d;
      busy_q <= busy_d;
    end
  end

  assign MGMT_CLK_OUT     = mdc_q;
  assign MGMT_DATA_OUT    = do_q;
  assign MGMT_DATA_OE_OUT = oe_q;
  assign MGMT_BUSY_OUT    = busy_q;
  assign MGMT_DONE_OUT    = done_q;
  assign MGMT_RDATA_OUT   = rd_q;

endmodule : mii_rx_sta

// [verilog/mii_rx_sta_pkg.sv]
package mii_rx_sta_pkg;

  // =====================================================================
  // clocking
  // =====================================================================
  localparam int unsigned CORE_CLK_HZ    = 100_000_000;
  localparam int unsigned MGMT_CLK_HZ    = 1_500_000;
  // half period of the management clock, rounded down so the rate never falls below 1.5 MHz
  localparam int unsigned MGMT_HALF_CYC  = CORE_CLK_HZ / (2 * MGMT_CLK_HZ);
  localparam int unsigned MGMT_DIV_W     = 6;

  // =====================================================================
  // management frame layout
  // =====================================================================
  localparam int unsigned PREAMBLE_BITS  = 32;
  localparam int unsigned FRAME_BITS     = 64;
  localparam int unsigned BIT_CNT_W      = 7;
  localparam int unsigned TA_BIT_POS     = 46;  // first turnaround bit in the frame
  localparam int unsigned DATA_BIT_POS   = 48;  // first data bit in the frame
  localparam logic [1:0]  START_CODE     = 2'h1;
  localparam logic [1:0]  OP_WRITE       = 2'h1;
  localparam logic [1:0]  OP_READ        = 2'h2;
  localparam logic [1:0]  TA_WRITE       = 2'h2;

  // =====================================================================
  // receive stream
  // =====================================================================
  localparam int unsigned NIBBLE_W       = 4;
  localparam int unsigned FIFO_DEPTH     = 8;
  // word layout: {last, error, collision, nibble}
  localparam int unsigned WORD_W         = NIBBLE_W + 3;
  localparam int unsigned WORD_LAST_BIT  = 6;
  localparam int unsigned WORD_ERR_BIT   = 5;
  localparam int unsigned WORD_COL_BIT   = 4;

  // management sequencer states, gray from idle through done; the return to idle flips both bits
  typedef enum logic [1:0] {
    MG_IDLE  = 2'b00,
    MG_SHIFT = 2'b01,
    MG_DONE  = 2'b11
  } mgmt_state_e;

endpackage : mii_rx_sta_pkg

// [verilog/rx_word_fifo.sv]
`timescale 1ns/100ps
// =======================================================================
// synchronous fifo, honest full and empty
// =======================================================================
module rx_word_fifo #(
  parameter int unsigned WIDTH = 7,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic      [WIDTH-1:0] rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  // =====================================================================
  // pointer and count update
  // =====================================================================
  always_comb begin
    push = wr_valid_in && (cnt_q != (AW+1)'(DEPTH));
    pop  = rd_ready_in && (cnt_q != '0);
    wp_d = push ? ((wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1) : wp_q;
    rp_d = pop  ? ((rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1) : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // storage has no reset; contents are only read when count says so
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wp_q] <= wr_data_in;
    end
  end

  assign wr_ready_out = (cnt_q != (AW+1)'(DEPTH));
  assign rd_valid_out = (cnt_q != '0);
  assign rd_data_out  = mem_q[rp_q];

endmodule : rx_word_fifo

// [bench/mii_rx_sta_props.sv]
`timescale 1ns/100ps
// =====================================================================
// port-level checks: management timing, status syncs, stream hold
// =====================================================================
module mii_rx_sta_props (
  input wire logic       CORE_CLK_IN,
  input wire logic       RST_IN,
  input wire logic       COLLISION_IN,
  input wire logic       CARRIER_IN,
  input wire logic       MGMT_INT_N_IN,
  input wire logic       RX_STREAM_READY_IN,
  input wire logic       COLLISION_OUT,
  input wire logic       CARRIER_OUT,
  input wire logic       MGMT_INT_OUT,
  input wire logic       MGMT_CLK_OUT,
  input wire logic       MGMT_DATA_OUT,
  input wire logic       MGMT_DATA_OE_OUT,
  input wire logic       MGMT_BUSY_OUT,
  input wire logic       MGMT_DONE_OUT,
  input wire logic       RX_STREAM_VALID_OUT,
  input wire logic [3:0] RX_DATA_OUT,
  input wire logic       RX_LAST_OUT
);
  logic [6:0]  hi_cnt_q;
  logic [12:0] busy_cnt_q;

  // phase and frame counters; the frame counter saturates so a stuck busy cannot wrap back into range
  always_ff @(posedge CORE_CLK_IN) begin
    hi_cnt_q <= MGMT_CLK_OUT ? hi_cnt_q + 7'h1 : 7'h0;
    if (RST_IN || !MGMT_BUSY_OUT) busy_cnt_q <= 13'h0;
    else if (busy_cnt_q != 13'h1fff) busy_cnt_q <= busy_cnt_q + 13'h1;
  end

  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);

  a_mdc_high: assert property ($fell(MGMT_CLK_OUT) |-> hi_cnt_q == 7'h21)
    else $error("mgmt clock high phase wrong");
  a_data_stable: assert property (MGMT_CLK_OUT |-> $stable(MGMT_DATA_OUT))
    else $error("mgmt data moved while clock high");
  a_mgmt_idle: assert property (!MGMT_BUSY_OUT && !$past(MGMT_BUSY_OUT)
    |-> !MGMT_CLK_OUT && !MGMT_DATA_OE_OUT) else $error("mgmt pins active when idle");
  a_frame_len: assert property (MGMT_DONE_OUT
    |-> busy_cnt_q inside {[13'h1040:13'h10cc]}) else $error("mgmt frame length wrong");
  a_col_sync: assert property ($rose(COLLISION_IN)
    |-> !COLLISION_OUT ##[1:4] COLLISION_OUT) else $error("collision sync wrong");
  a_crs_sync: assert property ($fell(CARRIER_IN)
    |-> CARRIER_OUT ##[1:4] !CARRIER_OUT) else $error("carrier sync wrong");
  a_int_sync: assert property ($fell(MGMT_INT_N_IN) |-> ##[1:4] MGMT_INT_OUT)
    else $error("interrupt not seen");
  a_stream_hold: assert property (RX_STREAM_VALID_OUT && !RX_STREAM_READY_IN
    |=> RX_STREAM_VALID_OUT && $stable(RX_DATA_OUT) && $stable(RX_LAST_OUT))
    else $error("stream word dropped before accept");

  c_done: cover property (MGMT_DONE_OUT);
  c_last: cover property (RX_STREAM_VALID_OUT && RX_STREAM_READY_IN && RX_LAST_OUT);
  c_col: cover property ($rose(COLLISION_OUT));
endmodule : mii_rx_sta_props

bind mii_rx_sta mii_rx_sta_props u_props (.CORE_CLK_IN, .RST_IN, .COLLISION_IN,
  .CARRIER_IN, .MGMT_INT_N_IN, .RX_STREAM_READY_IN, .COLLISION_OUT, .CARRIER_OUT,
  .MGMT_INT_OUT, .MGMT_CLK_OUT, .MGMT_DATA_OUT, .MGMT_DATA_OE_OUT, .MGMT_BUSY_OUT,
  .MGMT_DONE_OUT, .RX_STREAM_VALID_OUT, .RX_DATA_OUT, .RX_LAST_OUT);

// [bench/phy_model.sv]
`timescale 1ns/100ps
// =====================================================================
// transceiver stand-in: receive link, management slave, status pins
// =====================================================================
module phy_model (
  input  wire logic mdc_in,
  input  wire logic md_dev_in,
  input  wire logic md_oe_in,
  output logic      md_out,
  output logic      rx_clk_out,
  output logic [3:0] rx_nib_out,
  output logic      rx_dv_out,
  output logic      rx_er_out,
  output logic      col_out,
  output logic      crs_out,
  output logic      int_n_out
);
  logic [63:0] fr;
  logic [15:0] rd_val;
  logic        drv, drv_d, rd;
  int          cnt, nfr;

  // shared line; released means the pull-up level
  assign md_out = md_oe_in ? md_dev_in : (drv ? drv_d : 1'b1);

  initial begin
    {rx_clk_out, rx_dv_out, rx_er_out, col_out, crs_out, drv, rd} = '0;
    rx_nib_out = 4'h0;
    {int_n_out, drv_d} = 2'h3;
    {cnt, nfr} = '0;
  end

  // bits taken at the rise; read data launched a little after it
  always @(posedge mdc_in) begin
    if (cnt != 0 || md_oe_in) begin
      fr = {fr[62:0], md_out};
      if (cnt == 45) rd = (fr[11:10] == 2'h2);
      if (cnt == 45) rd_val = {fr[9:5], fr[4:0], fr[9:5] ^ fr[4:0], 1'b1};
      if (rd && cnt == 46) {drv, drv_d} <= #20 2'h2;
      if (rd && cnt > 46 && cnt < 63) drv_d <= #20 rd_val[62-cnt];
      if (cnt == 63) {drv, rd} <= #20 2'h0;
      if (cnt == 63) nfr++;
      cnt = (cnt == 63) ? 0 : cnt + 1;
    end
  end

  // clock only runs while this task is busy; idle link stands still
  task automatic tick(input int n);
    repeat (n) begin
      #80 rx_clk_out = 1'b1;
      #80 rx_clk_out = 1'b0;
    end
  endtask : tick

  task automatic send(input logic [63:0] d, input int n, input int e, input logic c);
    crs_out = 1'b1;
    col_out = c;
    tick(2);
    for (int i = 0; i < n; i++) begin
      rx_nib_out = d[4*i +: 4];
      rx_dv_out = 1'b1;
      rx_er_out = (i == e);
      tick(1);
    end
    {rx_dv_out, rx_er_out} = 2'h0;
    rx_nib_out = ~rx_nib_out;
    tick(4);
    {crs_out, col_out} = 2'h0;
  endtask : send
endmodule : phy_model

// [bench/tb.sv]
`timescale 1ns/100ps
// =====================================================================
// bench: stream scoreboard, management frames, status pins
// =====================================================================
module tb;
  logic        clk, rst, rdy, hold, drop, start, wr;
  logic [4:0]  pa, ra;
  logic [15:0] wd, rdata;
  logic [3:0]  rx_nib, data;
  logic [6:0]  w;
  logic        rx_clk, rx_dv, rx_er, col, crs, int_n, last, bad, colw, sv, ovf;
  logic        col_o, crs_o, int_o, mdc, md_in, md_o, md_oe, busy, done;
  logic [6:0]  q[$];
  int          miscompares, samples_checked, cycles, seed;

  mii_rx_sta dut (.CORE_CLK_IN(clk), .RST_IN(rst), .RX_CLK_IN(rx_clk),
    .RX_NIBBLE_IN(rx_nib), .RX_VALID_IN(rx_dv), .RX_ERROR_IN(rx_er),
    .COLLISION_IN(col), .CARRIER_IN(crs), .RX_DATA_OUT(data), .RX_LAST_OUT(last),
    .RX_BAD_OUT(bad), .RX_COL_OUT(colw), .RX_STREAM_VALID_OUT(sv),
    .RX_STREAM_READY_IN(rdy), .RX_OVERFLOW_OUT(ovf), .COLLISION_OUT(col_o),
    .CARRIER_OUT(crs_o), .MGMT_CLK_OUT(mdc), .MGMT_DATA_IN(md_in),
    .MGMT_DATA_OUT(md_o), .MGMT_DATA_OE_OUT(md_oe), .MGMT_INT_N_IN(int_n),
    .MGMT_INT_OUT(int_o), .MGMT_START_IN(start), .MGMT_WRITE_IN(wr),
    .MGMT_PHY_ADDR_IN(pa), .MGMT_REG_ADDR_IN(ra), .MGMT_WDATA_IN(wd),
    .MGMT_BUSY_OUT(busy), .MGMT_DONE_OUT(done), .MGMT_RDATA_OUT(rdata));

  phy_model phy (.mdc_in(mdc), .md_dev_in(md_o), .md_oe_in(md_oe), .md_out(md_in),
    .rx_clk_out(rx_clk), .rx_nib_out(rx_nib), .rx_dv_out(rx_dv), .rx_er_out(rx_er),
    .col_out(col), .crs_out(crs), .int_n_out(int_n));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (e !== g) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      miscompares++;
    end
  endtask : chk

  task automatic end_sim();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  // hang guard, well above the longest expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      end_sim();
    end
  end

  // consumer with random back-pressure; each accepted word against the model queue
  always @(negedge clk) rdy <= !hold && ($random(seed) % 3 != 0);
  always @(posedge clk) begin
    if (!rst && sv && rdy && !drop) begin
      w = 'x;
      if (q.size() != 0) w = q.pop_front();
      chk("rx_word", w, {last, bad, colw, data});
    end
  end

  // expected words: held-back last flag, error sticky from its nibble on
  task automatic frame(input int n, input int e, input logic c);
    logic [63:0] d;
    logic        b;
    d = {$random(seed), $random(seed)};
    b = 1'b0;
    for (int i = 0; i < n; i++) begin
      b = b | (i == e);
      q.push_back({(i == n - 1), b, c, d[4*i +: 4]});
    end
    phy.send(d, n, e, c);
  endtask : frame

  // one command, plus a second start while busy that must be ignored
  task automatic mgmt(input logic x, input logic [4:0] p, input logic [4:0] r);
    int n;
    n = phy.nfr;
    {wr, pa, ra, wd, start} = {x, p, r, 16'($random(seed)), 1'b1};
    @(negedge clk);
    start = 1'b0;
    chk("busy", 1, busy);
    repeat (100) @(negedge clk);
    {pa, start} = {~p, 1'b1};
    @(negedge clk);
    start = 1'b0;
    for (int k = 0; k < 5000 && done !== 1'b1; k++) @(negedge clk);
    chk("mgmt_done", 1, done);
    chk("mgmt_idle", 0, busy);
    chk("frames", n + 1, phy.nfr);
    chk("preamble", 32'hffff_ffff, phy.fr[63:32]);
    chk("st_op", {mii_rx_sta_pkg::START_CODE, x ? mii_rx_sta_pkg::OP_WRITE
      : mii_rx_sta_pkg::OP_READ}, phy.fr[31:28]);
    chk("addrs", {p, r}, phy.fr[27:18]);
    if (x) chk("wdata", {mii_rx_sta_pkg::TA_WRITE, wd}, phy.fr[17:0]);
    else chk("rdata", {p, r, p ^ r, 1'b1}, rdata);
    @(negedge clk);
  endtask : mgmt

  initial begin
    {rst, rdy, hold, drop, start, wr} = 6'h20;
    {pa, ra, wd} = '0;
    {miscompares, samples_checked, cycles} = '0;
    seed = 32'h942c;
    // reset must also see a few link clock edges
    fork
      phy.tick(3);
      repeat (10) @(negedge clk);
    join
    @(negedge clk);
    rst = 1'b0;
    frame(8, -1, 1'b0);
    frame(6, 2, 1'b1);
    frame(1, 0, 1'b0);
    repeat (200) @(negedge clk);
    chk("rx_drained", 0, q.size());
    chk("no_ovf", 0, ovf);
    chk("crs_idle", 0, crs_o);
    for (int k = 0; k < 4; k++) mgmt(k[0], 5'($random(seed)), 5'($random(seed)));
    // status pins together: interrupt low, collision and carrier high
    {phy.int_n_out, phy.col_out, phy.crs_out} = 3'h3;
    repeat (6) @(negedge clk);
    chk("int", 1, int_o);
    chk("col", 1, col_o);
    chk("crs", 1, crs_o);
    {phy.int_n_out, phy.col_out, phy.crs_out} = 3'h4;
    repeat (6) @(negedge clk);
    chk("int_idle", 0, int_o);
    chk("col_idle", 0, col_o);
    chk("crs_low", 0, crs_o);
    {hold, drop} = 2'h3;
    frame(16, -1, 1'b0);
    repeat (100) @(negedge clk);
    chk("overflow", 1, ovf);
    end_sim();
  end
endmodule : tb
